// ==== src/pxcd_device.sv ====
// Expander end: four watched inputs with change flags, twelve outputs.
// Assumes a free-running link clock much faster than SCL; all pins are
// oversampled through two flip-flops on that clock.
`timescale 1ns/10ps
module pxcd_device (
  // Link clock and reset
  input  wire logic       link_clk_i,
  input  wire logic       rst_b_i,
  // Two-wire bus
  pxcd_if.device          bus,
  // Port pins
  input  wire logic [3:0] watched_inputs_i,
  input  wire logic       addr_select_low_pin_i,
  input  wire logic       addr_select_high_pin_i,
  output logic      [3:0] output_group_a_o,       // Port byte bits 7, 6, 1, 0
  output logic      [7:0] output_group_b_o,
  // Open-drain interrupt
  output logic            int_o,
  output logic            int_oe_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_ADDR  = 3'h1,
    D_AACK  = 3'h2,
    D_WDATA = 3'h3,
    D_WACK  = 3'h4,
    D_RDATA = 3'h5,
    D_RACK  = 3'h6
  } pxcd_dstate_t;

  pxcd_dstate_t state_q, state_d;
  logic [7:0]   raw, s1_q, s2_q;
  logic         scl, sda, plo, phi, scl_p_q, sda_p_q;
  logic [3:0]   in_s, diff, snap_q, flag_q, hold_q, mask_q, outa_q, own_addr;
  logic [7:0]   outb_q, tx_byte, sh_q, sh_d;
  logic [3:0]   cnt_q, cnt_d;
  logic [1:0]   nscl_q, nsda_q, init_q;
  logic         scl_rise, scl_fall, start, stop, hit_a, hit_b, busy_q;
  logic         oe_q, oe_d, grp_b_q, grp_b_d, rd_q, rd_d, pair_q, pair_d;
  logic         ack_q, ack_d, samp, wr_apply, int_oe_q;

  // ----------------------------------------------------------------------
  // Pin synchronisers and bus edges
  // ----------------------------------------------------------------------
  assign raw = {watched_inputs_i, addr_select_high_pin_i, addr_select_low_pin_i,
                bus.sda, bus.scl};

  // Every pin comes from outside this clock, so two stages before use
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q    <= pxcd_pkg::SYNC_RST;
      s2_q    <= pxcd_pkg::SYNC_RST;
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      s1_q    <= raw;
      s2_q    <= s1_q;
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  // Named views of the synchronised pins
  assign scl      = s2_q[0];
  assign sda      = s2_q[1];
  assign plo      = s2_q[2];
  assign phi      = s2_q[3];
  assign in_s     = s2_q[7:4];
  assign scl_rise = scl & ~scl_p_q;
  assign scl_fall = ~scl & scl_p_q;
  assign start    = scl & scl_p_q & sda_p_q & ~sda;
  assign stop     = scl & scl_p_q & ~sda_p_q & sda;

  // ----------------------------------------------------------------------
  // Address select decoding
  // ----------------------------------------------------------------------
  // Track whether each select pin disagreed with SCL or SDA since the last START
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'h0;
      nscl_q <= 2'h0;
      nsda_q <= 2'h0;
    end else if (start) begin
      busy_q <= 1'h1;
      nscl_q <= 2'h0;
      nsda_q <= 2'h0;
    end else begin
      busy_q <= busy_q & ~stop;
      if (busy_q) begin
        nscl_q <= nscl_q | ({phi, plo} ^ {2{scl}});
        nsda_q <= nsda_q | ({phi, plo} ^ {2{sda}});
      end
    end
  end

  // Own address and the two group hits, taken when the address byte ends
  assign own_addr = {pxcd_pkg::hi_bits(pxcd_pkg::conn_of(phi, nscl_q[1], nsda_q[1])),
                     pxcd_pkg::lo_bits(pxcd_pkg::conn_of(plo, nscl_q[0], nsda_q[0]))};
  assign hit_a    = (sh_q[7:5] == pxcd_pkg::GRP_A_TOP) && (sh_q[4:1] == own_addr);
  assign hit_b    = (sh_q[7:5] == pxcd_pkg::GRP_B_TOP) && (sh_q[4:1] == own_addr);

  // Byte to send: group B readback, else port state or held flags by pair
  assign tx_byte = grp_b_q ? outb_q :
                   pair_q  ? {2'h0, hold_q, 2'h0} :
                             {outa_q[3:2], snap_q, outa_q[1:0]};

  // ----------------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------------
  // Bits move on SCL edges; SDA only changes after a falling SCL
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    oe_d     = oe_q;
    grp_b_d  = grp_b_q;
    rd_d     = rd_q;
    pair_d   = pair_q;
    ack_d    = ack_q;
    samp     = 1'h0;
    wr_apply = 1'h0;
    if (stop) begin
      state_d = D_IDLE;
      oe_d    = 1'h0;
      rd_d    = 1'h0;
    end else if (start) begin
      state_d = D_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'h0;
    end else begin
      unique case (state_q)
        D_IDLE: begin
        end
        D_ADDR, D_WDATA: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == pxcd_pkg::BYTE_BITS) begin
            if (state_q == D_WDATA) begin
              state_d = D_WACK;
              oe_d    = 1'h1;
            end else if (hit_a | hit_b) begin
              state_d = D_AACK;
              oe_d    = 1'h1;
              grp_b_d = hit_b;
            end else begin
              state_d = D_IDLE;
            end
          end
        end
        D_AACK: begin
          if (scl_rise) begin
            samp   = 1'h1;
            rd_d   = (sh_q[0] == pxcd_pkg::RW_READ);
            pair_d = 1'h0;
          end else if (scl_fall) begin
            cnt_d = 4'h0;
            oe_d  = 1'h0;
            if (rd_q) begin
              state_d = D_RDATA;
              sh_d    = tx_byte;
              oe_d    = ~tx_byte[7];
              cnt_d   = 4'h1;
            end else begin
              state_d = D_WDATA;
            end
          end
        end
        D_WACK: begin
          if (scl_rise) begin
            wr_apply = 1'h1;
          end else if (scl_fall) begin
            state_d = D_WDATA;
            oe_d    = 1'h0;
            cnt_d   = 4'h0;
          end
        end
        D_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == pxcd_pkg::BYTE_BITS) begin
              state_d = D_RACK;
              oe_d    = 1'h0;
            end else begin
              oe_d  = ~sh_q[6];
              sh_d  = {sh_q[6:0], 1'h0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            ack_d  = ~sda;
            pair_d = pair_q ^ ~sda;
            samp   = ~sda & ~grp_b_q & pair_q;
          end else if (scl_fall) begin
            if (ack_q) begin
              state_d = D_RDATA;
              sh_d    = tx_byte;
              oe_d    = ~tx_byte[7];
              cnt_d   = 4'h1;
            end else begin
              state_d = D_IDLE;
            end
          end
        end
        default: state_d = D_IDLE;
      endcase
    end
  end

  // Slave registers
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= D_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      oe_q    <= 1'h0;
      grp_b_q <= 1'h0;
      rd_q    <= 1'h0;
      pair_q  <= 1'h0;
      ack_q   <= 1'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      oe_q    <= oe_d;
      grp_b_q <= grp_b_d;
      rd_q    <= rd_d;
      pair_q  <= pair_d;
      ack_q   <= ack_d;
    end
  end

  // ----------------------------------------------------------------------
  // Ports, snapshot and change flags
  // ----------------------------------------------------------------------
  assign diff = snap_q ^ in_s;

  // Outputs and mask; straps are caught once the synchronisers hold real levels
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      init_q <= pxcd_pkg::INIT_CYC;
      outa_q <= 4'h0;
      outb_q <= 8'h00;
      mask_q <= pxcd_pkg::MASK_RST;
    end else if (init_q != 2'h0) begin
      init_q <= init_q - 2'h1;
      if (init_q == pxcd_pkg::INIT_LAST) begin
        outa_q <= {phi, phi, plo, plo};
        outb_q <= {{4{phi}}, {4{plo}}};
      end
    end else if (wr_apply) begin
      if (grp_b_q)
        outb_q <= sh_q;
      else begin
        outa_q <= {sh_q[7:6], sh_q[1:0]};
        mask_q <= sh_q[5:2];
      end
    end
  end

  // A change seen in the sampling cycle lands in the held copy, never lost
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      snap_q <= 4'h0;
      flag_q <= 4'h0;
      hold_q <= 4'h0;
    end else if (init_q != 2'h0) begin
      snap_q <= in_s;
    end else if (samp) begin
      snap_q <= in_s;
      hold_q <= flag_q | diff;
      flag_q <= 4'h0;
    end else begin
      flag_q <= flag_q | diff;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // Flags cleared at the address acknowledge drop the request there; a read
  // holds it off, and only changes after the last resample survive to STOP
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      int_oe_q <= 1'h0;
    else
      int_oe_q <= (|(flag_q & mask_q)) & ~rd_q;
  end

  assign int_o            = 1'h0;
  assign int_oe_o         = int_oe_q;
  assign bus.d_sda_o      = 1'h0;
  assign bus.d_sda_oe     = oe_q;
  assign output_group_a_o = outa_q;
  assign output_group_b_o = outb_q;

endmodule

// ==== src/pxcd_if.sv ====
// Two-wire bus between the master end and the expander end.
// Assumes the bench ties the select pins; the wire is pulled up here.
`timescale 1ns/10ps
interface pxcd_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic sda;

  // Open-drain resolution with an implied pullup
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport device (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

// ==== src/pxcd_master.sv ====
// Bus master end: runs one command at a time and makes SCL by a divider.
// Assumes the user holds write data valid until it is taken.
`timescale 1ns/10ps
module pxcd_master #(
  parameter int unsigned QCYC = pxcd_pkg::QUARTER_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Two-wire bus
  pxcd_if.master          bus,
  // Command
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic [6:0] cmd_addr_i,
  input  wire logic       cmd_read_i,
  input  wire logic [3:0] cmd_len_i,
  // Data
  input  wire logic [7:0] wr_data_i,
  output logic            wr_take_o,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o,
  output logic            done_o,
  output logic            nack_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,
    M_START = 2'h1,
    M_BIT   = 2'h2,
    M_STOP  = 2'h3
  } pxcd_mstate_t;

  pxcd_mstate_t state_q;
  logic [15:0]  div_q;
  logic [1:0]   q_q;
  logic [3:0]   bit_q, cnt_q;
  logic [7:0]   sh_q, rd_data_q;
  logic         s1_q, sda_s, scl_q, oe_q, rd_q, addr_q, nack_q;
  logic         take_q, rv_q, done_q, tick, tx, drv;

  // ----------------------------------------------------------------------
  // Timing and bit decoding
  // ----------------------------------------------------------------------
  assign tick = (div_q == 16'(QCYC - 1));
  assign tx   = addr_q | ~rd_q;
  // Data bits driven by the sender, the 9th by the receiver; last read byte gets no ack
  assign drv  = (bit_q != pxcd_pkg::ACK_BIT) ? (tx & ~sh_q[7]) :
                (~tx & (cnt_q != 4'h1));

  // SDA returns from the wire, so it is synchronised first
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q  <= 1'h1;
      sda_s <= 1'h1;
    end else begin
      s1_q  <= bus.sda;
      sda_s <= s1_q;
    end
  end

  // Quarter-period divider, idle outside a transfer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      div_q <= 16'h0000;
    else if (state_q == M_IDLE || tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  // Each bit: SDA set mid-low, SCL high for two quarters, sampled at the end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= M_IDLE;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rd_data_q <= 8'h00;
      scl_q <= 1'h1;
      oe_q <= 1'h0;
      rd_q <= 1'h0;
      addr_q <= 1'h0;
      nack_q <= 1'h0;
      take_q <= 1'h0;
      rv_q <= 1'h0;
      done_q <= 1'h0;
    end else begin
      take_q <= 1'h0;
      rv_q   <= 1'h0;
      done_q <= 1'h0;
      unique case (state_q)
        M_IDLE: if (cmd_valid_i) begin
          state_q <= M_START;
          sh_q    <= {cmd_addr_i, cmd_read_i};
          rd_q    <= cmd_read_i;
          cnt_q   <= cmd_len_i;
          addr_q  <= 1'h1;
          nack_q  <= 1'h0;
          q_q     <= 2'h0;
          oe_q    <= 1'h1;
        end
        M_START: if (tick) begin
          q_q <= q_q + 2'h1;
          if (q_q == 2'h1) begin
            state_q <= M_BIT;
            scl_q   <= 1'h0;
            q_q     <= 2'h0;
            bit_q   <= 4'h0;
          end
        end
        M_BIT: if (tick) begin
          q_q <= q_q + 2'h1;
          unique case (q_q)
            2'h0: oe_q  <= drv;
            2'h1: scl_q <= 1'h1;
            2'h2: begin
            end
            2'h3: begin
              scl_q <= 1'h0;
              if (bit_q != pxcd_pkg::ACK_BIT) begin
                sh_q  <= {sh_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
              end else begin
                bit_q <= 4'h0;
                if (!addr_q && rd_q) begin
                  rd_data_q <= sh_q;
                  rv_q      <= 1'h1;
                end
                if (tx && sda_s) begin
                  nack_q  <= 1'h1;
                  state_q <= M_STOP;
                end else if (addr_q ? (cnt_q == 4'h0) : (cnt_q == 4'h1)) begin
                  state_q <= M_STOP;
                end else begin
                  if (!addr_q)
                    cnt_q <= cnt_q - 4'h1;
                  addr_q <= 1'h0;
                  if (!rd_q) begin
                    sh_q   <= wr_data_i;
                    take_q <= 1'h1;
                  end
                end
              end
            end
          endcase
        end
        M_STOP: if (tick) begin
          q_q <= q_q + 2'h1;
          unique case (q_q)
            2'h0: oe_q  <= 1'h1;
            2'h1: scl_q <= 1'h1;
            2'h2: oe_q  <= 1'h0;
            2'h3: begin
              state_q <= M_IDLE;
              done_q  <= 1'h1;
            end
          endcase
        end
      endcase
    end
  end

  assign cmd_ready_o  = (state_q == M_IDLE);
  assign bus.scl      = scl_q;
  assign bus.m_sda_o  = 1'h0;
  assign bus.m_sda_oe = oe_q;
  assign wr_take_o    = take_q;
  assign rd_data_o    = rd_data_q;
  assign rd_valid_o   = rv_q;
  assign done_o       = done_q;
  assign nack_o       = nack_q;

endmodule

// ==== src/pxcd_pkg.sv ====
// Shared constants and helpers for the port expander with change detection.
// Assumes both bus ends and the bench compile this package first.
package pxcd_pkg;

  // ----------------------------------------------------------------------
  // Slave address
  // ----------------------------------------------------------------------
  localparam logic [2:0] GRP_A_TOP = 3'h6;  // Mixed input/output group
  localparam logic [2:0] GRP_B_TOP = 3'h5;  // Eight push-pull outputs
  localparam logic       RW_READ   = 1'h1;

  // Connection of a four-level address select pin
  typedef enum logic [1:0] {
    CONN_GND = 2'h0,
    CONN_VDD = 2'h1,
    CONN_SCL = 2'h2,
    CONN_SDA = 2'h3
  } pxcd_conn_t;

  // Upper pin gives address bits 3..2
  function automatic logic [1:0] hi_bits(pxcd_conn_t c);
    unique case (c)
      CONN_SCL: hi_bits = 2'h0;
      CONN_SDA: hi_bits = 2'h1;
      CONN_GND: hi_bits = 2'h2;
      CONN_VDD: hi_bits = 2'h3;
    endcase
  endfunction

  // Lower pin gives address bits 1..0
  function automatic logic [1:0] lo_bits(pxcd_conn_t c);
    unique case (c)
      CONN_GND: lo_bits = 2'h0;
      CONN_VDD: lo_bits = 2'h1;
      CONN_SCL: lo_bits = 2'h2;
      CONN_SDA: lo_bits = 2'h3;
    endcase
  endfunction

  // A pin that never disagreed with a bus line during the transfer follows it
  function automatic pxcd_conn_t conn_of(logic lvl, logic nscl, logic nsda);
    if (!nscl)
      conn_of = CONN_SCL;
    else if (!nsda)
      conn_of = CONN_SDA;
    else
      conn_of = lvl ? CONN_VDD : CONN_GND;
  endfunction

  // ----------------------------------------------------------------------
  // Byte framing and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;  // Bits before the acknowledge
  localparam logic [3:0] ACK_BIT   = 4'h8;  // Index of the 9th clock
  localparam logic [3:0] MASK_RST  = 4'h0;  // All inputs masked
  localparam logic [7:0] SYNC_RST  = 8'h0f; // Bus and select lines idle high
  localparam logic [1:0] INIT_CYC  = 2'h3;  // Wait for synchronisers to fill
  localparam logic [1:0] INIT_LAST = 2'h1;  // Cycle on which straps are caught

  // ----------------------------------------------------------------------
  // Timing of the master's serial clock
  // ----------------------------------------------------------------------
  localparam int SCL_PERIOD_NS = 2500;      // 400 kHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int QUARTER_CYC   = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

endpackage

// ==== test/pxcd_bus_chk.sv ====
// Checker of the two-wire link between master and expander.
// Assumes the master runs with a quarter of 4 clocks.
`timescale 1ns/10ps
module pxcd_bus_chk (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Bus signals
  input  wire logic scl,
  input  wire logic m_sda_o,
  input  wire logic m_sda_oe,
  input  wire logic d_sda_o,
  input  wire logic d_sda_oe,
  input  wire logic sda
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic       scl_q;
  logic       sda_q;
  logic       fb_q;
  logic [3:0] nb_q;
  wire        rise = scl & ~scl_q;
  wire        strt = scl & scl_q & sda_q & ~sda;
  // Bit count: the ack slot is only known by position
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      nb_q  <= 4'h0;
      fb_q  <= 1'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      nb_q  <= strt ? 4'h0 : (rise ? ((nb_q == 4'h8) ? 4'h0 : nb_q + 4'h1) : nb_q);
      fb_q  <= strt | (fb_q & ~(rise & (nb_q == 4'h8)));
    end
  end
  // ----
  // Wire rules
  // ----
  a_master_od: assert property (m_sda_oe |-> !m_sda_o)
    else $error("master drives sda high");
  a_device_od: assert property (d_sda_oe |-> !d_sda_o)
    else $error("device drives sda high");
  a_dev_change: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device sda moved while scl high");
  a_dev_quiet: assert property (strt |-> !d_sda_oe [*8])
    else $error("device drives at start");
  a_start_clock: assert property (strt |-> ##[1:16] !scl)
    else $error("no clock after start");
  a_stop_idle: assert property (scl && scl_q && !sda_q && sda |-> scl [*4])
    else $error("bus not idle after stop");
  a_scl_high: assert property ($rose(scl) |-> scl [*6])
    else $error("scl high too short");
  a_scl_low: assert property ($fell(scl) |-> !scl [*6])
    else $error("scl low too short");
  a_addr_ack: assert property (rise && fb_q && nb_q == 4'h8 |-> !sda)
    else $error("address not acknowledged");
  cover property (strt);
  cover property (rise && fb_q && nb_q == 4'h8 && !sda);
  cover property ($rose(d_sda_oe));
endmodule

// ==== test/tb_top.sv ====
// Bench joining master and expander over the bus interface.
// Assumes QCYC 4; low select pin high, high select pin low or following SCL.
`timescale 1ns/10ps
module tb_top;
  logic       clk_i;
  logic       link_clk;
  logic       rst_b_i;
  logic       cmd_valid;
  logic [6:0] cmd_addr;
  logic       cmd_read;
  logic [3:0] cmd_len;
  logic [7:0] wr_data;
  logic [3:0] inp;
  logic [3:0] out_a;
  logic [7:0] out_b;
  logic       int_oe;
  logic       cmd_ready;
  logic       wr_take;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       done;
  logic       nack;
  logic       int_lvl;
  logic       sel_scl;
  logic       sel_hi;
  logic [7:0] rdb [4];
  int         err_count;
  int         n_checks;
  localparam logic [6:0] ADR_A = {pxcd_pkg::GRP_A_TOP, 4'h9};
  localparam logic [6:0] ADR_B = {pxcd_pkg::GRP_B_TOP, 4'h9};
  localparam logic [6:0] ADR_S = {pxcd_pkg::GRP_A_TOP, 4'h1};
  pxcd_if bus ();
  // High select pin is grounded, or tied to the clock wire to move the address
  assign sel_hi = sel_scl & bus.scl;
  pxcd_master #(.QCYC(4)) u_pxcd_master (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(bus),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_addr_i(cmd_addr),
    .cmd_read_i(cmd_read), .cmd_len_i(cmd_len), .wr_data_i(wr_data), .wr_take_o(wr_take),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .done_o(done), .nack_o(nack));
  pxcd_device u_pxcd_device (.link_clk_i(link_clk), .rst_b_i(rst_b_i), .bus(bus),
    .watched_inputs_i(inp), .addr_select_low_pin_i(1'h1), .addr_select_high_pin_i(sel_hi),
    .output_group_a_o(out_a), .output_group_b_o(out_b), .int_o(int_lvl), .int_oe_o(int_oe));
  pxcd_bus_chk u_pxcd_bus_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl(bus.scl),
    .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe), .d_sda_o(bus.d_sda_o),
    .d_sda_oe(bus.d_sda_oe), .sda(bus.sda));
  // Clocks: link clock free of any phase tie to the system clock
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    link_clk = 1'h0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One command; entered at a falling edge, waits on done with a bound
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [3:0] n,
                      input logic [15:0] wd);
    int k;
    int t;
    k = 0;
    t = 0;
    cmd_valid = 1'h1;
    cmd_addr = a;
    cmd_read = rd;
    cmd_len = n;
    wr_data = wd[15:8];
    @(negedge clk_i);
    cmd_valid = 1'h0;
    while (done !== 1'h1 && t < 4000) begin
      @(negedge clk_i);
      t++;
      if (wr_take === 1'h1) wr_data = wd[7:0];
      if (rd_valid === 1'h1 && k < 4) begin
        rdb[k] = rd_data;
        k++;
      end
    end
    if (t >= 4000) chk("done", 8'h01, 8'h00);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog: about fourteen times the expected run
  initial begin
    #1000000;
    err_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    rst_b_i = 1'h0;
    cmd_valid = 1'h0;
    cmd_addr = 7'h00;
    cmd_read = 1'h0;
    cmd_len = 4'h0;
    wr_data = 8'h00;
    inp = 4'h0;
    sel_scl = 1'h0;
    err_count = 0;
    n_checks = 0;
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'h1;
    repeat (8) @(negedge clk_i);
    chk("out_a", 8'h03, {4'h0, out_a});
    chk("out_b", 8'h0f, out_b);
    xfer(ADR_A, 1'h0, 4'h1, 16'h9500);
    chk("out_a", 8'h09, {4'h0, out_a});
    chk("ready", 8'h01, {7'h0, cmd_ready});
    chk("int_o", 8'h00, {7'h0, int_lvl});
    xfer(ADR_B, 1'h0, 4'h2, 16'ha53c);
    chk("out_b", 8'h3c, out_b);
    xfer(ADR_B, 1'h1, 4'h1, 16'h0000);
    chk("rd_b", 8'h3c, rdb[0]);
    $display("test write done");
    inp = 4'h2;
    repeat (6) @(negedge clk_i);
    inp = 4'h0;
    repeat (10) @(negedge clk_i);
    chk("int", 8'h00, {7'h0, int_oe});
    xfer(ADR_A, 1'h1, 4'h2, 16'h0000);
    chk("rd0", 8'h81, rdb[0]);
    chk("rd1", 8'h08, rdb[1]);
    $display("test flags done");
    inp = 4'h1;
    repeat (10) @(negedge clk_i);
    chk("int", 8'h01, {7'h0, int_oe});
    fork
      xfer(ADR_A, 1'h1, 4'h3, 16'h0000);
      begin
        repeat (200) @(negedge clk_i);
        chk("int", 8'h00, {7'h0, int_oe});
        inp = 4'h5;
      end
    join
    chk("rd0", 8'h85, rdb[0]);
    chk("rd1", 8'h04, rdb[1]);
    chk("rd2", 8'h95, rdb[2]);
    repeat (10) @(negedge clk_i);
    chk("int", 8'h00, {7'h0, int_oe});
    $display("test long read done");
    fork
      xfer(ADR_A, 1'h1, 4'h1, 16'h0000);
      begin
        repeat (200) @(negedge clk_i);
        inp = 4'h4;
        repeat (20) @(negedge clk_i);
        chk("int", 8'h00, {7'h0, int_oe});
      end
    join
    chk("rd0", 8'h95, rdb[0]);
    repeat (10) @(negedge clk_i);
    chk("int", 8'h01, {7'h0, int_oe});
    $display("test deferral done");
    sel_scl = 1'h1;
    xfer(ADR_S, 1'h0, 4'h1, 16'h4200);
    chk("nack", 8'h00, {7'h0, nack});
    chk("out_a", 8'h06, {4'h0, out_a});
    chk("int", 8'h00, {7'h0, int_oe});
    $display("test select done");
    stop_test();
  end
endmodule
